// [rtl/bus_master_config_register.sv]
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "bmc_cfg.svh"
// Functional notes
// [R1] Writing one to reset bit starts soft reset.
// [R2] Software stops transmit and receive before writing.
// [R3] Reserved bits read zero, writes ignored.
// [R4] Wait bit set: one wait per data phase.
// [R5] Wait bit clear: no wait states.
// [R6] Byte order bit selects descriptor endianness.
// [R7] Alignment field sets burst address boundary.
// [R8] Misaligned start: first burst ends on boundary.
// [R9] Later bursts start on chosen boundary.
// [R10] Software programs nonzero alignment after reset.
// [R11] Codes 01/10/11 mean 8/16/32 long words.
// [R12] Soft reset clears fields, keeps bit zero.
module bus_master_config_register #(
  parameter int ADDR_W = 30,
  parameter int LEN_W  = 16
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic [31:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [31:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output bmc_pkg::bm_cfg_t          cfg,
  output logic                      soft_reset_pulse,
  input  wire logic                 data_phase_active,
  output logic                      data_phase_done,
  input  wire logic                 desc_valid,
  input  wire logic [31:0]          desc_word_in,
  output logic [31:0]               desc_word_out,
  output logic                      desc_out_valid,
  input  wire logic                 burst_req,
  input  wire logic [ADDR_W-1:0]    burst_addr,
  input  wire logic [LEN_W-1:0]     burst_words,
  output logic [LEN_W-1:0]          burst_len,
  output logic                      burst_len_valid
);

  // ****************************************
  // Parameter checks
  // ****************************************
  if (LEN_W < 6 || ADDR_W < 5) begin : g_bad_param
    $error("LEN_W must be at least 6 and ADDR_W at least 5");
  end

  // ****************************************
  // Register bus slave
  // ****************************************
  bmc_pkg::bm_cfg_t  cfg_r;
  logic              aw_got_r;
  logic              w_got_r;
  logic [31:0]       awaddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r;
  logic              swrst_r;
  logic              aw_now;
  logic              w_now;
  logic              wr_fire;
  logic [31:0]       wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              wr_hit;
  logic [31:0]       reg_view;

  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready  = !w_got_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign aw_now        = s_axi_awvalid && s_axi_awready;
  assign w_now         = s_axi_wvalid && s_axi_wready;
  assign wr_fire       = (aw_got_r || aw_now) && (w_got_r || w_now) && !bvalid_r;
  assign wr_addr       = aw_got_r ? awaddr_r : s_axi_awaddr;
  assign wr_data       = w_got_r ? wdata_r : s_axi_wdata;
  assign wr_strb       = w_got_r ? wstrb_r : s_axi_wstrb;
  assign wr_hit        = {wr_addr[31:2], 2'b00} == `BMC_REG_OFFSET;

  // Reserved positions are never stored, so they always read back as zero.
  always_comb begin
    reg_view                            = 32'h0000_0000; // [R3]
    reg_view[`BMC_WAIT_BIT]             = cfg_r.wait_insert;
    reg_view[`BMC_BIG_END_BIT]          = cfg_r.descriptor_byte_order_select;
    reg_view[`BMC_ALIGN_HI:`BMC_ALIGN_LO] = cfg_r.burst_alignment_boundary;
    reg_view[`BMC_SWRST_BIT]            = cfg_r.sw_reset_bit;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_r <= 1'b0;
      awaddr_r <= 32'h0000_0000;
    end else if (wr_fire) begin
      aw_got_r <= 1'b0;
    end else if (aw_now) begin
      aw_got_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      w_got_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (wr_fire) begin
      w_got_r <= 1'b0;
    end else if (w_now) begin
      w_got_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `AXI_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= `AXI_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      if ({s_axi_araddr[31:2], 2'b00} == `BMC_REG_OFFSET) begin
        rdata_r <= reg_view;
        rresp_r <= `AXI_RESP_OKAY;
      end else begin
        rdata_r <= 32'h0000_0000;
        rresp_r <= `AXI_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;

  // ****************************************
  // Configuration register and soft reset
  // ****************************************
  // The soft reset lands one cycle after the write, so the fields written
  // in the same word are cleared again; only the reset bit itself survives.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= bmc_pkg::bm_cfg_t'(5'h00);
    end else begin
      if (swrst_r) begin
        cfg_r.wait_insert                  <= 1'b0; // [R12]
        cfg_r.descriptor_byte_order_select <= 1'b0;
        cfg_r.burst_alignment_boundary     <= bmc_pkg::ALIGN_RSVD;
      end else if (wr_fire && wr_hit) begin
        if (wr_strb[2]) begin
          cfg_r.wait_insert                  <= wr_data[`BMC_WAIT_BIT];
          cfg_r.descriptor_byte_order_select <= wr_data[`BMC_BIG_END_BIT];
        end
        if (wr_strb[1]) begin
          cfg_r.burst_alignment_boundary <=
            bmc_pkg::align_code_t'(wr_data[`BMC_ALIGN_HI:`BMC_ALIGN_LO]);
        end
      end
      if (wr_fire && wr_hit && wr_strb[0]) begin
        cfg_r.sw_reset_bit <= wr_data[`BMC_SWRST_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      swrst_r <= 1'b0;
    end else begin
      swrst_r <= wr_fire && wr_hit && wr_strb[0] && wr_data[`BMC_SWRST_BIT]; // [R1]
    end
  end

  assign cfg              = cfg_r;
  assign soft_reset_pulse = swrst_r;

  // ****************************************
  // Data phase wait insertion
  // ****************************************
  logic wait_done_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_done_r <= 1'b0;
    end else if (swrst_r || !data_phase_active || data_phase_done) begin
      wait_done_r <= 1'b0;
    end else begin
      wait_done_r <= 1'b1; // [R4]
    end
  end

  assign data_phase_done = data_phase_active && (!cfg_r.wait_insert || wait_done_r); // [R4] [R5]

  // ****************************************
  // Descriptor byte order
  // ****************************************
  logic [31:0] desc_out_r;
  logic        desc_vld_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      desc_out_r <= 32'h0000_0000;
      desc_vld_r <= 1'b0;
    end else begin
      desc_vld_r <= desc_valid && !swrst_r;
      if (desc_valid) begin
        desc_out_r <= cfg_r.descriptor_byte_order_select ? // [R6]
          {desc_word_in[7:0], desc_word_in[15:8], desc_word_in[23:16], desc_word_in[31:24]} :
          desc_word_in;
      end
    end
  end

  assign desc_word_out  = desc_out_r;
  assign desc_out_valid = desc_vld_r;

  // ****************************************
  // Burst alignment planner
  // ****************************************
  logic [5:0]        boundary;
  logic [LEN_W-1:0]  to_edge;
  logic [LEN_W-1:0]  len_r;
  logic              len_vld_r;
  logic [ADDR_W-1:0] addr_seen_r;
  logic [LEN_W-1:0]  rem_seen_r;

  always_comb begin
    unique case (cfg_r.burst_alignment_boundary) // [R11]
      bmc_pkg::ALIGN_8:    boundary = 6'h08;
      bmc_pkg::ALIGN_16:   boundary = 6'h10;
      bmc_pkg::ALIGN_32:   boundary = 6'h20;
      bmc_pkg::ALIGN_RSVD: boundary = 6'h00;
    endcase
  end

  // A reserved code imposes no boundary; software must avoid it.
  assign to_edge = LEN_W'(boundary - (6'(burst_addr[4:0]) & (boundary - 6'h01))); // [R7]

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      len_r       <= '0;
      len_vld_r   <= 1'b0;
      addr_seen_r <= '0;
      rem_seen_r  <= '0;
    end else begin
      len_vld_r <= burst_req && !swrst_r;
      if (burst_req) begin
        addr_seen_r <= burst_addr;
        rem_seen_r  <= burst_words;
        if (boundary != 6'h00 && to_edge < burst_words) begin
          len_r <= to_edge; // [R8] [R9]
        end else begin
          len_r <= burst_words;
        end
      end
    end
  end

  assign burst_len       = len_r;
  assign burst_len_valid = len_vld_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  AST_SOFT_RESET: assert property ( // [R1]
    wr_fire && wr_hit && wr_strb[0] && wr_data[0] |=> soft_reset_pulse ##1 !soft_reset_pulse)
    else $error("soft reset pulse missing or too long");
  AST_RSVD_ZERO: assert property ( // [R3]
    rvalid_r |-> rdata_r[31:22] == 10'h000 && rdata_r[19:16] == 4'h0)
    else $error("reserved bits read nonzero");
  AST_ONE_WAIT: assert property ( // [R4]
    data_phase_active && cfg_r.wait_insert && !data_phase_done ##1
    data_phase_active && cfg_r.wait_insert |-> data_phase_done)
    else $error("wait state not exactly one");
  AST_WAIT_FIRST: assert property ( // [R4]
    $rose(data_phase_active) && cfg_r.wait_insert |-> !data_phase_done)
    else $error("wait state not inserted");
  AST_NO_WAIT: assert property ( // [R5]
    data_phase_active && !cfg_r.wait_insert |-> data_phase_done)
    else $error("wait inserted while disabled");
  AST_DESC_ORDER: assert property ( // [R6]
    desc_valid && cfg_r.descriptor_byte_order_select |=>
    desc_out_r == {$past(desc_word_in[7:0]), $past(desc_word_in[15:8]),
                   $past(desc_word_in[23:16]), $past(desc_word_in[31:24])})
    else $error("descriptor bytes not swapped");
  AST_ALIGN_END: assert property ( // [R8]
    len_vld_r && boundary != 6'h00 && len_r != rem_seen_r |->
    ((5'(addr_seen_r[4:0]) + 5'(len_r)) & (5'(boundary) - 5'h01)) == 5'h00)
    else $error("burst does not end on boundary");
  AST_DECODE: assert property ( // [R11]
    cfg_r.burst_alignment_boundary != bmc_pkg::ALIGN_RSVD |->
    boundary == 6'h04 << cfg_r.burst_alignment_boundary)
    else $error("alignment code decoded wrongly");
  AST_SOFT_KEEP: assert property ( // [R12]
    soft_reset_pulse |=> !cfg_r.wait_insert && cfg_r.burst_alignment_boundary == 2'b00
    && cfg_r.sw_reset_bit == $past(cfg_r.sw_reset_bit))
    else $error("soft reset result wrong");

  COV_SOFT_RESET: cover property (soft_reset_pulse);
  COV_WAIT_PHASE: cover property (data_phase_active && cfg_r.wait_insert ##1 data_phase_done);
  COV_SPLIT_BURST: cover property (len_vld_r && len_r != rem_seen_r);
  COV_BIG_DESC: cover property (desc_out_valid && cfg_r.descriptor_byte_order_select);

endmodule // bus_master_config_register

// [pkg/bmc_cfg.svh]
`ifndef BMC_CFG_SVH
`define BMC_CFG_SVH
`define BMC_REG_OFFSET   32'h0000_0000
`define BMC_SWRST_BIT    0
`define BMC_ALIGN_LO     14
`define BMC_ALIGN_HI     15
`define BMC_BIG_END_BIT  20
`define BMC_WAIT_BIT     21
`define BMC_RSVD_MASK    32'hFFCF_3FFE
`define BMC_RESET_VALUE  32'h0000_0000
`define BMC_WAIT_STATES  1
`define AXI_RESP_OKAY    2'h0
`define AXI_RESP_SLVERR  2'h2
`endif

// [pkg/bmc_pkg.sv]
package bmc_pkg;
  typedef enum logic [1:0] {
    ALIGN_RSVD = 2'b00,
    ALIGN_8    = 2'b01,
    ALIGN_16   = 2'b10,
    ALIGN_32   = 2'b11
  } align_code_t;
  typedef struct packed {
    logic        wait_insert;
    logic        descriptor_byte_order_select;
    align_code_t burst_alignment_boundary;
    logic        sw_reset_bit;
  } bm_cfg_t;
endpackage

// [sim/host_mem_model.sv]
`timescale 1ns/1ps
// ********
// Host memory side: runs a train of data phases and counts their cycles.
// ********
module host_mem_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       go,
  input  wire logic [7:0] phases,
  input  wire logic       data_phase_done,
  output logic            data_phase_active,
  output logic [15:0]     cycles
);
  logic [7:0] left_r;
  // A phase ends only when the target allows it, so the memory never shortens a wait.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_phase_active <= 1'b0;
      left_r            <= 8'h00;
      cycles            <= 16'h0000;
    end else if (go && !data_phase_active) begin
      data_phase_active <= 1'b1;
      left_r            <= phases;
      cycles            <= 16'h0000;
    end else if (data_phase_active) begin
      cycles <= cycles + 16'h0001;
      if (data_phase_done) begin
        left_r <= left_r - 8'h01;
        if (left_r == 8'h01) begin
          data_phase_active <= 1'b0;
        end
      end
    end
  end
endmodule // host_mem_model

// [sim/bus_master_config_register_bench.sv]
`timescale 1ns/1ps
module bus_master_config_register_bench;
  logic             sys_clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic [31:0]      awaddr, wdata, araddr, rdata, desc_in, desc_out;
  logic [3:0]       wstrb;
  logic [1:0]       bresp, rresp;
  logic             awready, wready, bvalid, arready, rvalid, swp, dpa, dpd;
  logic             dv, dov, breq, blv, go;
  logic [29:0]      baddr;
  logic [15:0]      bwords, blen, cyc;
  logic [7:0]       nph;
  bmc_pkg::bm_cfg_t cfg;
  int               fails, num_checks, pulses;

  bus_master_config_register u_bus_master_config_register (
    .sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cfg(cfg),
    .soft_reset_pulse(swp), .data_phase_active(dpa), .data_phase_done(dpd),
    .desc_valid(dv), .desc_word_in(desc_in), .desc_word_out(desc_out),
    .desc_out_valid(dov), .burst_req(breq), .burst_addr(baddr), .burst_words(bwords),
    .burst_len(blen), .burst_len_valid(blv));
  host_mem_model u_host_mem_model (
    .sys_clk(sys_clk), .rst_n(rst_n), .go(go), .phases(nph),
    .data_phase_done(dpd), .data_phase_active(dpa), .cycles(cyc));

  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (swp) pulses++;

  // ********
  // Shared tasks.
  // ********
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic axw(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge sys_clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (i == 64) begin fails++; final_report(); end
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
    int i;
    @(posedge sys_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        chk(rdata, e);
        chk({30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
        break;
      end
    end
    if (i == 64) begin fails++; final_report(); end
  endtask
  task automatic bst(input int a, input int n, input int e);
    breq <= 1'b1; baddr <= 30'(a); bwords <= 16'(n);
    @(posedge sys_clk);
    breq <= 1'b0;
    @(posedge sys_clk);
    chk({31'h0, blv}, 32'h1);
    chk({16'h0, blen}, 32'(e));
  endtask

  // ********
  // Scenarios.
  // ********
  task automatic t_regs();
    logic [1:0] r;
    rd_chk(32'h0, 32'h0, 2'h0);
    axw(32'h0, 32'hFFFF_FFFE, r);
    rd_chk(32'h0, 32'h0030_C000, 2'h0);
    chk({27'h0, cfg}, 32'h1E);
    axw(32'h4, 32'h0000_4000, r);
    chk({30'h0, r}, 32'h2);
    rd_chk(32'h4, 32'h0, 2'h2);
    rd_chk(32'h0, 32'h0030_C000, 2'h0);
    wstrb <= 4'h2;
    axw(32'h0, 32'h0000_0000, r);
    wstrb <= 4'hF;
    chk({30'h0, r}, 32'h0);
    rd_chk(32'h0, 32'h0030_0000, 2'h0);
    $display("test regs done");
  endtask
  task automatic t_wait();
    logic [1:0] r;
    int i;
    for (int w = 0; w < 2; w++) begin
      axw(32'h0, w ? 32'h0020_4000 : 32'h0000_4000, r);
      nph <= 8'h05; go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      for (i = 0; i < 64; i++) begin
        @(posedge sys_clk);
        if (!dpa) break;
      end
      if (i == 64) begin fails++; final_report(); end
      chk({16'h0, cyc}, w ? 32'hA : 32'h5);
    end
    $display("test wait done");
  endtask
  task automatic t_desc();
    logic [1:0] r;
    for (int w = 0; w < 2; w++) begin
      axw(32'h0, w ? 32'h0010_4000 : 32'h0000_4000, r);
      desc_in <= 32'h1122_3344; dv <= 1'b1;
      @(posedge sys_clk);
      dv <= 1'b0;
      @(posedge sys_clk);
      chk({31'h0, dov}, 32'h1);
      chk(desc_out, w ? 32'h4433_2211 : 32'h1122_3344);
    end
    $display("test desc done");
  endtask
  task automatic t_burst();
    logic [1:0] r;
    for (int c = 1; c < 4; c++) begin
      axw(32'h0, 32'(c) << 14, r);
      bst(3, 100, (4 << c) - 3);
      bst(4 << c, 100, 4 << c);
      bst((4 << c) + 2, 3, 3);
    end
    axw(32'h0, 32'h0, r);
    bst(3, 100, 100);
    $display("test burst done");
  endtask
  task automatic t_soft();
    logic [1:0] r;
    int p0;
    p0 = pulses;
    axw(32'h0, 32'h0030_C001, r);
    chk({30'h0, r}, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk(32'(pulses - p0), 32'h1);
    rd_chk(32'h0, 32'h0000_0001, 2'h0);
    axw(32'h0, 32'h0, r);
    rd_chk(32'h0, 32'h0, 2'h0);
    chk(32'(pulses - p0), 32'h1);
    $display("test soft done");
  endtask

  initial begin
    sys_clk = 1'b0; rst_n = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 32'h0; wdata = 32'h0; araddr = 32'h0;
    wstrb = 4'hF; desc_in = 32'h0; dv = 1'b0; breq = 1'b0; baddr = 30'h0;
    bwords = 16'h0; go = 1'b0; nph = 8'h00; fails = 0; num_checks = 0; pulses = 0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs();
    t_wait();
    t_desc();
    t_burst();
    t_soft();
    final_report();
  end
endmodule // bus_master_config_register_bench
